// file: common/pulse_gen_pkg.sv
/*
 * Shared constants of the two-channel pulse generator: register offsets,
 * configuration bit positions, reset values and tick timing.
 * Assumes a 100 MHz system clock and an 8-bit register port behind the serial interface.
 */
package pulse_gen_pkg;
    localparam logic [7:0] OFS_PULSE1_CYCLE_LENGTH = 8'h30;
    localparam logic [7:0] OFS_PULSE1_ON_DURATION  = 8'h31;
    localparam logic [7:0] OFS_PULSE2_START_DELAY  = 8'h32;
    localparam logic [7:0] OFS_PULSE_CONFIG        = 8'h35;

    localparam int CFG_PULSE1_INVERT   = 7;
    localparam int CFG_PULSE1_HIGH_SEL = 6;
    localparam int CFG_PULSE1_CYCLE_SEL = 5;
    localparam int CFG_PULSE1_RUN      = 4;
    localparam int CFG_PULSE2_INVERT   = 3;
    localparam int CFG_PULSE2_HIGH_SEL = 2;
    localparam int CFG_PULSE2_CYCLE_SEL = 1;
    localparam int CFG_PULSE2_RUN      = 0;

    localparam logic [7:0] RST_REG_VALUE = 8'h00;

    localparam int CLK_PERIOD_NS    = 10;
    localparam int FAST_TICK_NS     = 1000000;
    localparam int FAST_TICK_CYCLES = FAST_TICK_NS / CLK_PERIOD_NS;
    localparam int FAST_TICK_MS     = 1;
    localparam int SLOW_TICK_MS     = 125;
    localparam int SLOW_TICK_RATIO  = SLOW_TICK_MS / FAST_TICK_MS;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DELAY = 2'b01,
        ST_RUN   = 2'b10
    } chan_state_t;
endpackage : pulse_gen_pkg

// file: src/pulse_channel.sv
/*
 * One pulse generator channel: initial delay, then on time and period counted in ticks.
 * Assumes one-cycle tick pulses from the parent, the slow tick always coinciding with a fast one.
 */
module pulse_channel (
    input  wire logic       i_sys_clk,   // System clock.
    input  wire logic       i_rst,       // Asynchronous reset, active high.
    input  wire logic       i_run,       // Channel enable.
    input  wire logic       i_invert,    // Output inversion.
    input  wire logic       i_fast_tick, // 1 ms tick pulse.
    input  wire logic       i_slow_tick, // 125 ms tick pulse.
    input  wire logic       i_cycle_sel, // Period tick select, 1 = slow.
    input  wire logic       i_high_sel,  // On-time tick select, 1 = slow.
    input  wire logic [7:0] i_delay,     // Initial delay count.
    input  wire logic [7:0] i_cycle,     // Period count.
    input  wire logic [7:0] i_high,      // On-time count.
    output logic            o_wave       // Pulse output.
);
    import pulse_gen_pkg::*;

    chan_state_t state;
    chan_state_t next_state;
    logic [7:0]  cnt;
    logic [7:0]  next_cnt;
    logic [7:0]  hcnt;
    logic [7:0]  next_hcnt;
    logic        next_wave;
    logic        cyc_tick;
    logic        high_tick;
    logic        wrap;
    logic        on;

    always_comb begin
        cyc_tick   = i_cycle_sel ? i_slow_tick : i_fast_tick;
        high_tick  = i_high_sel ? i_slow_tick : i_fast_tick;
        wrap       = cyc_tick && (({1'b0, cnt} + 9'h001) >= {1'b0, i_cycle});
        on         = (state == ST_RUN) && (i_cycle != 8'h00) && (hcnt < i_high);
        next_state = state;
        next_cnt   = cnt;
        next_hcnt  = hcnt;
        case (state)
            ST_IDLE: begin
                if (i_run) begin
                    next_state = ST_DELAY;
                    next_cnt   = 8'h00;
                    next_hcnt  = 8'h00;
                end
            end
            ST_DELAY: begin
                if (!i_run) begin
                    next_state = ST_IDLE;
                end else if (cnt == i_delay) begin
                    next_state = ST_RUN;
                    next_cnt   = 8'h00;
                    next_hcnt  = 8'h00;
                end else if (cyc_tick) begin
                    next_cnt = cnt + 8'h01;
                end
            end
            ST_RUN: begin
                if (!i_run) begin
                    next_state = ST_IDLE;
                end else if (wrap) begin
                    next_cnt  = 8'h00;
                    next_hcnt = 8'h00;
                end else begin
                    if (cyc_tick) begin
                        next_cnt = cnt + 8'h01;
                    end
                    if (high_tick && (hcnt < i_high)) begin
                        next_hcnt = hcnt + 8'h01;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // A disabled channel shows the off level at once, whatever state it was in.
        next_wave = (i_run && on) ^ i_invert;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state  <= ST_IDLE;
            cnt    <= 8'h00;
            hcnt   <= 8'h00;
            o_wave <= 1'b0;
        end else begin
            state  <= next_state;
            cnt    <= next_cnt;
            hcnt   <= next_hcnt;
            o_wave <= next_wave;
        end
    end

    AST_CYCLE_WRAP: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (state == ST_RUN) && i_run && wrap |=> (cnt == 8'h00) && (hcnt == 8'h00))
        else $error("Period counter did not restart at the end of the period.");
    AST_CYCLE_TICK: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (state == ST_RUN) && i_run && !wrap && !cyc_tick |=> cnt == $past(cnt))
        else $error("Period counter moved without a period tick.");
    AST_HIGH_STEP: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (state == ST_RUN) && i_run && !wrap && high_tick && (hcnt < i_high) |=> hcnt == $past(hcnt) + 8'h01)
        else $error("On-time counter missed a tick.");
    AST_DELAY_OFF: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (state == ST_DELAY) |=> o_wave == $past(i_invert))
        else $error("Pulse appeared during the initial delay.");
    AST_DELAY_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (state == ST_DELAY) && i_run && (cnt != i_delay) && !cyc_tick |=> (state == ST_DELAY) && (cnt == $past(cnt)))
        else $error("Delay advanced without a period tick.");
    AST_FAST_SELECT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (state == ST_DELAY) && i_run && (cnt != i_delay) && !i_cycle_sel && i_fast_tick && !i_slow_tick
        |=> cnt == $past(cnt) + 8'h01)
        else $error("Clear period select did not count the 1 ms tick.");
    AST_IDLE_OFF: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !i_run |=> o_wave == $past(i_invert))
        else $error("Disabled channel did not show its off level.");
    AST_ON_LEVEL: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_run && on |=> o_wave != $past(i_invert))
        else $error("Channel not at its on level during the on time.");

    COV_DELAY_DONE: cover property (@(posedge i_sys_clk) disable iff (i_rst)
        (state == ST_DELAY) ##1 (state == ST_RUN));
    COV_WRAP: cover property (@(posedge i_sys_clk) disable iff (i_rst) (state == ST_RUN) && i_run && wrap);
    COV_ON_TO_OFF: cover property (@(posedge i_sys_clk) disable iff (i_rst) i_run && on ##1 i_run && !on);
endmodule : pulse_channel

// file: src/pulse_gen_top.sv
/*
 * Two-channel pulse generator timing: register file for channel 1 period and on time,
 * channel 2 initial delay and the shared configuration, plus the 1 ms and 125 ms time bases.
 * Assumes an 8-bit register port decoded behind the serial interface; the counts that live
 * in other blocks arrive as plain inputs.
 */
module pulse_gen_top #(
    parameter int FAST_CYCLES = pulse_gen_pkg::FAST_TICK_CYCLES, // Clock cycles per 1 ms tick.
    parameter int SLOW_RATIO  = pulse_gen_pkg::SLOW_TICK_RATIO   // Fast ticks per 125 ms tick.
) (
    input  wire logic       i_sys_clk,            // System clock, 100 MHz.
    input  wire logic       i_rst,                // Asynchronous reset, active high.
    input  wire logic [7:0] i_reg_addr,           // Register address.
    input  wire logic [7:0] i_reg_wdata,          // Register write data.
    input  wire logic       i_reg_wr,             // Write strobe.
    input  wire logic       i_reg_rd,             // Read strobe.
    input  wire logic [7:0] i_pulse1_delay_count, // Channel 1 initial delay.
    input  wire logic [7:0] i_pulse2_cycle_count, // Channel 2 period.
    input  wire logic [7:0] i_pulse2_high_count,  // Channel 2 on time.
    output logic      [7:0] o_reg_rdata,          // Read data, registered.
    output logic            o_pulse1_wave,        // Channel 1 output.
    output logic            o_pulse2_wave         // Channel 2 output.
);
    import pulse_gen_pkg::*;

    logic [7:0]  pulse1_cycle_count;
    logic [7:0]  pulse1_high_count;
    logic [7:0]  pulse2_delay_count;
    logic [7:0]  config_bits;
    logic [7:0]  next_pulse1_cycle_count;
    logic [7:0]  next_pulse1_high_count;
    logic [7:0]  next_pulse2_delay_count;
    logic [7:0]  next_config_bits;
    logic [7:0]  next_reg_rdata;
    logic [31:0] fast_cnt;
    logic [31:0] next_fast_cnt;
    logic [31:0] slow_cnt;
    logic [31:0] next_slow_cnt;
    logic        fast_tick;
    logic        slow_tick;
    logic        next_fast_tick;
    logic        next_slow_tick;

    function automatic logic [7:0] write_reg(input logic [7:0] cur, input logic [7:0] ofs);
        write_reg = (i_reg_wr && (i_reg_addr == ofs)) ? i_reg_wdata : cur;
    endfunction : write_reg

    always_comb begin
        next_pulse1_cycle_count = write_reg(pulse1_cycle_count, OFS_PULSE1_CYCLE_LENGTH);
        next_pulse1_high_count  = write_reg(pulse1_high_count, OFS_PULSE1_ON_DURATION);
        next_pulse2_delay_count = write_reg(pulse2_delay_count, OFS_PULSE2_START_DELAY);
        next_config_bits        = write_reg(config_bits, OFS_PULSE_CONFIG);
        next_reg_rdata = o_reg_rdata;
        if (i_reg_rd) begin
            case (i_reg_addr)
                OFS_PULSE1_CYCLE_LENGTH: next_reg_rdata = pulse1_cycle_count;
                OFS_PULSE1_ON_DURATION:  next_reg_rdata = pulse1_high_count;
                OFS_PULSE2_START_DELAY:  next_reg_rdata = pulse2_delay_count;
                OFS_PULSE_CONFIG:        next_reg_rdata = config_bits;
                default:                 next_reg_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pulse1_cycle_count <= RST_REG_VALUE;
            pulse1_high_count  <= RST_REG_VALUE;
            pulse2_delay_count <= RST_REG_VALUE;
            config_bits        <= RST_REG_VALUE;
            o_reg_rdata        <= 8'h00;
        end else begin
            pulse1_cycle_count <= next_pulse1_cycle_count;
            pulse1_high_count  <= next_pulse1_high_count;
            pulse2_delay_count <= next_pulse2_delay_count;
            config_bits        <= next_config_bits;
            o_reg_rdata        <= next_reg_rdata;
        end
    end

    // The slow base is built from the fast one so both stay phase aligned; a channel whose
    // period and on time use different bases then never sees a slow tick between fast ones.
    always_comb begin
        next_fast_tick = (fast_cnt == 32'(FAST_CYCLES - 1));
        next_fast_cnt  = next_fast_tick ? 32'h0000_0000 : fast_cnt + 32'h0000_0001;
        next_slow_cnt  = slow_cnt;
        next_slow_tick = 1'b0;
        if (next_fast_tick) begin
            next_slow_tick = (slow_cnt == 32'(SLOW_RATIO - 1));
            next_slow_cnt  = next_slow_tick ? 32'h0000_0000 : slow_cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            fast_cnt  <= 32'h0000_0000;
            slow_cnt  <= 32'h0000_0000;
            fast_tick <= 1'b0;
            slow_tick <= 1'b0;
        end else begin
            fast_cnt  <= next_fast_cnt;
            slow_cnt  <= next_slow_cnt;
            fast_tick <= next_fast_tick;
            slow_tick <= next_slow_tick;
        end
    end

    // Channel 1 has no initial delay register here, so it takes its delay from outside.
    pulse_channel u_chan1 (
        .i_sys_clk   (i_sys_clk),
        .i_rst       (i_rst),
        .i_run       (config_bits[CFG_PULSE1_RUN]),
        .i_invert    (config_bits[CFG_PULSE1_INVERT]),
        .i_fast_tick (fast_tick),
        .i_slow_tick (slow_tick),
        .i_cycle_sel (config_bits[CFG_PULSE1_CYCLE_SEL]),
        .i_high_sel  (config_bits[CFG_PULSE1_HIGH_SEL]),
        .i_delay     (i_pulse1_delay_count),
        .i_cycle     (pulse1_cycle_count),
        .i_high      (pulse1_high_count),
        .o_wave      (o_pulse1_wave)
    );

    pulse_channel u_chan2 (
        .i_sys_clk   (i_sys_clk),
        .i_rst       (i_rst),
        .i_run       (config_bits[CFG_PULSE2_RUN]),
        .i_invert    (config_bits[CFG_PULSE2_INVERT]),
        .i_fast_tick (fast_tick),
        .i_slow_tick (slow_tick),
        .i_cycle_sel (config_bits[CFG_PULSE2_CYCLE_SEL]),
        .i_high_sel  (config_bits[CFG_PULSE2_HIGH_SEL]),
        .i_delay     (pulse2_delay_count),
        .i_cycle     (i_pulse2_cycle_count),
        .i_high      (i_pulse2_high_count),
        .o_wave      (o_pulse2_wave)
    );

    AST_FAST_PERIOD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        fast_tick |=> !fast_tick && (fast_cnt == 32'h0000_0001))
        else $error("Fast tick spacing wrong.");
    AST_SLOW_ALIGN: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        slow_tick |-> fast_tick && (slow_cnt == 32'h0000_0000))
        else $error("Slow tick not aligned to a fast tick.");
    AST_REG_WRITE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_reg_wr && (i_reg_addr == OFS_PULSE1_CYCLE_LENGTH) |=> pulse1_cycle_count == $past(i_reg_wdata))
        else $error("Period register write lost.");
    // A write lands at the next edge, and a read answers with the contents before any write that same cycle.
    AST_HIGH_WRITE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_reg_wr && (i_reg_addr == OFS_PULSE1_ON_DURATION) |=> pulse1_high_count == $past(i_reg_wdata))
        else $error("On-time register write lost.");
    AST_DELAY_WRITE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_reg_wr && (i_reg_addr == OFS_PULSE2_START_DELAY) |=> pulse2_delay_count == $past(i_reg_wdata))
        else $error("Delay register write lost.");
    AST_CFG_WRITE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_reg_wr && (i_reg_addr == OFS_PULSE_CONFIG) |=> config_bits == $past(i_reg_wdata))
        else $error("Configuration register write lost.");
    AST_CYCLE_KEEP: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !(i_reg_wr && (i_reg_addr == OFS_PULSE1_CYCLE_LENGTH)) |=> pulse1_cycle_count == $past(pulse1_cycle_count))
        else $error("Period register changed without a write.");
    AST_READ_CYCLE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_reg_rd && (i_reg_addr == OFS_PULSE1_CYCLE_LENGTH) |=> o_reg_rdata == $past(pulse1_cycle_count))
        else $error("Period register read returned the wrong value.");
    AST_READ_HIGH: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_reg_rd && (i_reg_addr == OFS_PULSE1_ON_DURATION) |=> o_reg_rdata == $past(pulse1_high_count))
        else $error("On-time register read returned the wrong value.");
    AST_READ_DELAY: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_reg_rd && (i_reg_addr == OFS_PULSE2_START_DELAY) |=> o_reg_rdata == $past(pulse2_delay_count))
        else $error("Delay register read returned the wrong value.");
    AST_RDATA_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !i_reg_rd |=> o_reg_rdata == $past(o_reg_rdata))
        else $error("Read data changed without a read.");
    AST_PULSE1_OFF: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !config_bits[CFG_PULSE1_RUN] |=> o_pulse1_wave == $past(config_bits[CFG_PULSE1_INVERT]))
        else $error("Disabled channel one left its off level.");
    AST_PULSE2_OFF: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !config_bits[CFG_PULSE2_RUN] |=> o_pulse2_wave == $past(config_bits[CFG_PULSE2_INVERT]))
        else $error("Disabled channel two left its off level.");

    COV_SLOW_TICK: cover property (@(posedge i_sys_clk) disable iff (i_rst) slow_tick);
    COV_READ_CFG: cover property (@(posedge i_sys_clk) disable iff (i_rst) i_reg_rd && (i_reg_addr == OFS_PULSE_CONFIG));
endmodule : pulse_gen_top

// file: test/tb.sv
/*
 * Self-checking bench for the two-channel pulse generator timing block: register port,
 * channel one period and on time, channel two initial delay and the disabled level.
 * Assumes the shared package is compiled first; ticks are shortened through the top's parameters.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pulse_gen_pkg::*;

    localparam int FC = 4;
    localparam int SR = 3;

    logic       i_sys_clk;
    logic       i_rst;
    logic [7:0] i_reg_addr;
    logic [7:0] i_reg_wdata;
    logic       i_reg_wr;
    logic       i_reg_rd;
    logic [7:0] i_pulse1_delay_count;
    logic [7:0] i_pulse2_cycle_count;
    logic [7:0] i_pulse2_high_count;
    logic [7:0] o_reg_rdata;
    logic       o_pulse1_wave;
    logic       o_pulse2_wave;
    int         n_fail;
    int         n_tests;
    int         seed;

    pulse_gen_top #(.FAST_CYCLES(FC), .SLOW_RATIO(SR)) i_dut (
        .i_sys_clk           (i_sys_clk),
        .i_rst               (i_rst),
        .i_reg_addr          (i_reg_addr),
        .i_reg_wdata         (i_reg_wdata),
        .i_reg_wr            (i_reg_wr),
        .i_reg_rd            (i_reg_rd),
        .i_pulse1_delay_count(i_pulse1_delay_count),
        .i_pulse2_cycle_count(i_pulse2_cycle_count),
        .i_pulse2_high_count (i_pulse2_high_count),
        .o_reg_rdata         (o_reg_rdata),
        .o_pulse1_wave       (o_pulse1_wave),
        .o_pulse2_wave       (o_pulse2_wave)
    );

    always #5 i_sys_clk = ~i_sys_clk;

    // Clock cycles in one tick of the selected time base.
    function automatic int tk(input int slow);
        return slow ? FC * SR : FC;
    endfunction : tk

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        i_reg_wr    <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_sys_clk);
        i_reg_addr <= a;
        i_reg_rd   <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_rd   <= 1'b0;
        #1;
        d = o_reg_rdata;
    endtask : rd

    // The first period after enable may be short because ticks run free, so the span from the
    // second rising edge to the third is timed instead.
    task automatic measure(output int hi, output int per);
        int   rises;
        logic w;
        logic p;
        rises = 0;
        hi    = 0;
        per   = 0;
        p     = 1'b1;
        for (int k = 0; k < 4000 && rises < 3; k++) begin
            @(posedge i_sys_clk);
            #1;
            w = o_pulse1_wave;
            if (w === 1'b1 && p === 1'b0) rises++;
            if (rises == 2) begin
                per++;
                if (w === 1'b1) hi++;
            end
            p = w;
        end
    endtask : measure

    task automatic results();
        if (n_fail == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    initial begin
        #400000;
        n_fail++;
        results();
    end

    initial begin
        logic [7:0] v;
        logic [7:0] rv;
        logic [7:0] ofs [4];
        int         c, h, hs, cs, hi, per, d, lo, t;
        ofs = '{OFS_PULSE1_CYCLE_LENGTH, OFS_PULSE1_ON_DURATION, OFS_PULSE2_START_DELAY, OFS_PULSE_CONFIG};
        seed = 50836;
        n_fail = 0;
        n_tests = 0;
        i_sys_clk = 1'b0;
        i_rst = 1'b1;
        i_reg_addr = 8'h00;
        i_reg_wdata = 8'h00;
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        i_pulse1_delay_count = 8'({$random(seed)} % 4);
        i_pulse2_cycle_count = 8'h04;
        i_pulse2_high_count = 8'h02;
        repeat (12) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        chk({o_pulse1_wave, o_pulse2_wave}, 2'b00);
        foreach (ofs[k]) begin
            rd(ofs[k], rv);
            chk(rv, RST_REG_VALUE);
        end
        foreach (ofs[k]) begin
            v = 8'($random(seed));
            wr(ofs[k], v);
            rd(ofs[k], rv);
            chk(rv, v);
        end
        wr(8'h33, 8'($random(seed)));
        rd(8'h33, rv);
        chk(rv, 8'h00);
        wr(OFS_PULSE_CONFIG, 8'h88);
        repeat (3) @(posedge i_sys_clk);
        for (int k = 0; k < 40; k++) begin
            @(posedge i_sys_clk);
            chk({o_pulse1_wave, o_pulse2_wave}, 2'b11);
        end
        wr(OFS_PULSE_CONFIG, 8'h00);
        // Select pairs avoid a slow on-time tick under a fast period tick.
        for (int i = 0; i < 4; i++) begin
            c = 2 + {$random(seed)} % 4;
            h = 1 + {$random(seed)} % (c - 1);
            hs = (i == 2);
            cs = (i == 1 || i == 2);
            if (i == 3) begin
                c = 255;
                h = 128;
            end
            wr(OFS_PULSE1_CYCLE_LENGTH, 8'(c));
            wr(OFS_PULSE1_ON_DURATION, 8'(h));
            wr(OFS_PULSE_CONFIG, {1'b0, 1'(hs), 1'(cs), 1'b1, 4'h0});
            measure(hi, per);
            chk(per, c * tk(cs));
            chk(hi, h * tk(hs));
            wr(OFS_PULSE_CONFIG, 8'h00);
            repeat (3) @(posedge i_sys_clk);
            #1;
            chk(o_pulse1_wave, 1'b0);
        end
        for (int i = 0; i < 3; i++) begin
            d = (i == 0) ? 0 : 1 + {$random(seed)} % 6;
            cs = (i == 2);
            wr(OFS_PULSE2_START_DELAY, 8'(d));
            wr(OFS_PULSE_CONFIG, {6'h00, 1'(cs), 1'b1});
            t = 0;
            while (o_pulse2_wave !== 1'b1 && t < 1000) begin
                @(posedge i_sys_clk);
                #1;
                t++;
            end
            lo = (d > 0) ? (d - 1) * tk(cs) : 0;
            chk(t >= lo && t <= d * tk(cs) + 6, 1'b1);
            wr(OFS_PULSE_CONFIG, 8'h00);
            repeat (3) @(posedge i_sys_clk);
            #1;
            chk(o_pulse2_wave, 1'b0);
        end
        results();
    end
endmodule : tb
